//--- core/bus_seq_params.svh
// Purpose: constants for the separate-bus cycle sequencer
// Assumes: 100 MHz system clock
// Notes: definitions only
`ifndef BUS_SEQ_PARAMS_SVH
`define BUS_SEQ_PARAMS_SVH
`define ADDR_W 24
`define DATA_W 8
`define CS_W 4
`define LEN_W 4
`define LEN_MIN 4'h2
`define LEN_MAX 4'hF
`define LEN_ONE 4'h1
`define CNT_ZERO 4'h0
`endif

//--- core/bus_seq_pkg.sv
// Purpose: types shared by the sequencer files
// Assumes: included params header
// Notes: bus states of one cycle
package bus_seq_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_T1, ST_T2, ST_T3, ST_TW, ST_T4
   } bus_state_t;
endpackage

//--- core/state_timer_if.sv
// Purpose: link between sequencer and its state timer
// Assumes: one clock
// Notes: start reloads, last marks final cycle of a state
`timescale 1ns/10ps
interface state_timer_if;
   logic start;
   logic [3:0] len;
   logic last;
   logic half;
   modport ctrl (output start, output len, input last, input half);
   modport timer (input start, input len, output last, output half);
endinterface

//--- core/state_timer.sv
// Purpose: counts system clocks within one bus state
// Assumes: len already clamped to 2..15
// Notes: half marks the midpoint of the state
`timescale 1ns/10ps
`include "bus_seq_params.svh"
module state_timer (
   input wire logic clk_in,
   input wire logic resetn_in,
   state_timer_if.timer tif
);
   logic [`LEN_W-1:0] cnt_r;
   logic [`LEN_W-1:0] cnt_nxt;
   logic [`LEN_W-1:0] len_half;
   ////////////////////////////////////////////////////////////////////////
   // count up from zero; last when len-1 reached
   assign len_half = tif.len >> 1;
   assign cnt_nxt = tif.start ? `CNT_ZERO : cnt_r + `LEN_ONE;
   assign tif.last = (cnt_r == tif.len - `LEN_ONE);
   assign tif.half = (cnt_r >= len_half);
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cnt_r <= `CNT_ZERO;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule

//--- core/bus_seq.sv
// Purpose: runs read and write cycles on a strobe bus with
//          separate address and data buses
// Assumes: WAITN_IN comes from a pin; requests from same-clock logic
// Notes: rd, wr and request strobes are active low, latch strobe active high; all come from flip-flops
`timescale 1ns/10ps
`include "bus_seq_params.svh"
// Function
// - T3 holds bus; wait low extends
// - read data captured at T4 start
// - write takes four states plus waits
// - T1 drives address, select, data, strobe
// - latch strobe drops mid T1
// - T2 asserts read or write and request strobe
// - T4 releases write, holds buses
// - state length programmable 2 to 15
module bus_seq
   import bus_seq_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   input wire logic REQ_IN,
   input wire logic WRITE_IN,
   input wire logic IO_IN,
   input wire logic [`ADDR_W-1:0] ADDR_IN,
   input wire logic [`DATA_W-1:0] WDATA_IN,
   input wire logic [`CS_W-1:0] CS_SEL_IN,
   input wire logic [`LEN_W-1:0] STATE_LEN_IN,
   input wire logic WAITN_IN,
   input wire logic [`DATA_W-1:0] DATA_IN,
   output logic READY_OUT,
   output logic DONE_OUT,
   output logic [`DATA_W-1:0] RDATA_OUT,
   output logic [`ADDR_W-1:0] ADDR_OUT,
   output logic [`DATA_W-1:0] DATA_OUT,
   output logic DATA_OE_OUT,
   output logic [`CS_W-1:0] CS_N_OUT,
   output logic ALE_OUT,
   output logic RD_N_OUT,
   output logic WR_N_OUT,
   output logic MEMORY_REQUEST_N_OUT,
   output logic IO_REQUEST_N_OUT
);
   bus_state_t state_r, state_nxt;
   logic wait_s1_r, wait_s2_r;
   logic write_r, io_r;
   logic [`LEN_W-1:0] len_r;
   logic [`LEN_W-1:0] len_clamp;
   logic [`ADDR_W-1:0] addr_r;
   logic [`DATA_W-1:0] wdata_r, rdata_r;
   logic [`CS_W-1:0] cs_n_r;
   logic ale_r, rd_n_r, wr_n_r, memory_request_n_n_r, io_request_n_n_r, oe_r, done_r;
   logic take, st_end, enter_t3, enter_t4, waiting;
   state_timer_if tif ();

   ////////////////////////////////////////////////////////////////////////
   // overview of one cycle, L clocks per state:
   //   T1  address, select and write data appear; latch strobe pulses
   //   T2  read or write strobe falls with one request strobe
   //   T3  nothing on the bus moves; wait pin is judged at its end
   //   TW  optional, repeated while the synchronised wait pin is low
   //   T4  read data taken on its opening edge, rd/wr strobes rise
   // select, request strobes and write data drive end with T4, so a
   // peripheral never sees its select drop before its data strobe.
   //
   // timing of the wait pin:
   //   the pin passes two flip-flops, so it must be low two or three
   //   clocks before T3 ends to be seen; a pin pulled low as the
   //   strobe falls in T2 is always caught for lengths of 2 or more.
   //   a wait state is a whole state long, not one clock, which keeps
   //   the state timer simple at the cost of some extra latency.
   //
   // request handling:
   //   a request is taken only while idle; one raised in mid cycle is
   //   ignored, with no flag to say so, and the requester must hold it
   //   until ready is seen high.  all request fields are captured on
   //   the take edge, so the requester may change them afterwards.
   //
   // reset:
   //   every strobe and select comes out of reset inactive, so the bus
   //   is quiet until the first take; the state timer free-runs while
   //   idle but is reloaded by the take before its count matters.

   ////////////////////////////////////////////////////////////////////////
   // state timer
   state_timer u_timer (
      .clk_in(CLK_IN),
      .resetn_in(RESETN_IN),
      .tif(tif)
   );

   ////////////////////////////////////////////////////////////////////////
   // wait pin passes two flip-flops before use
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         wait_s1_r <= 1'b1;
         wait_s2_r <= 1'b1;
      end else begin
         wait_s1_r <= WAITN_IN;
         wait_s2_r <= wait_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // decode; out-of-range lengths clamp so a state never collapses
   assign len_clamp = (STATE_LEN_IN < `LEN_MIN) ? `LEN_MIN
                    : STATE_LEN_IN;
   assign take = (state_r == ST_IDLE) && REQ_IN;
   assign st_end = (state_r != ST_IDLE) && tif.last;
   assign waiting = !wait_s2_r;
   // wait sampled near the end of T3 decides entry to wait states
   assign enter_t3 = (state_r == ST_T2) && st_end;
   assign enter_t4 = ((state_r == ST_T3) && st_end && !waiting)
                  || ((state_r == ST_TW) && st_end && !waiting);
   assign tif.start = take || st_end;
   assign tif.len = take ? len_clamp : len_r;
   assign READY_OUT = (state_r == ST_IDLE);

   ////////////////////////////////////////////////////////////////////////
   // state sequence: T1, T2, T3, optional waits, T4
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: if (take) state_nxt = ST_T1;
         ST_T1: if (st_end) state_nxt = ST_T2;
         ST_T2: if (st_end) state_nxt = ST_T3;
         ST_T3: if (st_end) state_nxt = waiting ? ST_TW : ST_T4;
         ST_TW: if (st_end && !waiting) state_nxt = ST_T4;
         ST_T4: if (st_end) state_nxt = ST_IDLE;
         // two spare codes of the three-bit state fall back to idle
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // request capture; held for whole cycle so buses stay stable
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         write_r <= 1'b0;
         io_r <= 1'b0;
         len_r <= `LEN_MIN;
         addr_r <= '0;
         wdata_r <= '0;
      end else if (take) begin
         write_r <= WRITE_IN;
         io_r <= IO_IN;
         len_r <= len_clamp;
         addr_r <= ADDR_IN;
         wdata_r <= WDATA_IN;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // chip select, latch strobe and data drive
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         cs_n_r <= '1;
         ale_r <= 1'b0;
         oe_r <= 1'b0;
      end else if (take) begin
         cs_n_r <= ~CS_SEL_IN;
         ale_r <= 1'b1;
         oe_r <= WRITE_IN;
      end else if (state_r == ST_T4 && st_end) begin
         cs_n_r <= '1;
         oe_r <= 1'b0;
      end else if (state_r == ST_T1 && tif.half) begin
         ale_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read, write and request strobes, all active low
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         rd_n_r <= 1'b1;
         wr_n_r <= 1'b1;
         memory_request_n_n_r <= 1'b1;
         io_request_n_n_r <= 1'b1;
      end else if (state_r == ST_T1 && st_end) begin
         rd_n_r <= write_r;
         wr_n_r <= !write_r;
         memory_request_n_n_r <= io_r;
         io_request_n_n_r <= !io_r;
      end else if (enter_t4) begin
         rd_n_r <= 1'b1;
         wr_n_r <= 1'b1;
      end else if (state_r == ST_T4 && st_end) begin
         memory_request_n_n_r <= 1'b1;
         io_request_n_n_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data captured on the edge that opens T4
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         rdata_r <= '0;
         done_r <= 1'b0;
      end else begin
         if (enter_t4 && !write_r) begin
            rdata_r <= DATA_IN;
         end
         done_r <= (state_r == ST_T4) && st_end;
      end
   end

   assign ADDR_OUT = addr_r;
   assign DATA_OUT = wdata_r;
   assign DATA_OE_OUT = oe_r;
   assign CS_N_OUT = cs_n_r;
   assign ALE_OUT = ale_r;
   assign RD_N_OUT = rd_n_r;
   assign WR_N_OUT = wr_n_r;
   assign MEMORY_REQUEST_N_OUT = memory_request_n_n_r;
   assign IO_REQUEST_N_OUT = io_request_n_n_r;
   assign RDATA_OUT = rdata_r;
   assign DONE_OUT = done_r;
endmodule

//--- test/bus_seq_assertions.sv
// Purpose: strobe and timing checks on the sequencer pins
// Assumes: one clock, reset active low
// Notes: bound to bus_seq at the foot
`timescale 1ns/10ps
module bus_seq_assertions (
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   input wire logic READY_OUT,
   input wire logic DONE_OUT,
   input wire logic DATA_OE_OUT,
   input wire logic [23:0] ADDR_OUT,
   input wire logic [3:0] CS_N_OUT,
   input wire logic ALE_OUT,
   input wire logic RD_N_OUT,
   input wire logic WR_N_OUT,
   input wire logic MEMORY_REQUEST_N_OUT,
   input wire logic IO_REQUEST_N_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   // one request strobe only, so reads and writes share this
   wire one_req = MEMORY_REQUEST_N_OUT != IO_REQUEST_N_OUT;
   wire sel = CS_N_OUT != 4'hF;
   sequence ale_start; $rose(ALE_OUT); endsequence
   sequence wr_end; $rose(WR_N_OUT); endsequence
   a_ale_select: assert property (ale_start |-> sel)
      else $error("latch strobe without select");
   a_ale_drop: assert property (ale_start |-> ##[1:8] !ALE_OUT)
      else $error("latch strobe held too long");
   a_write_req: assert property ($fell(WR_N_OUT) |-> one_req)
      else $error("write strobe without one request");
   a_read_req: assert property ($fell(RD_N_OUT) |-> one_req)
      else $error("read strobe without one request");
   a_wr_release: assert property (wr_end |-> DATA_OE_OUT && sel)
      else $error("buses dropped with write strobe");
   a_done_bound: assert property (wr_end |-> ##[2:15] DONE_OUT)
      else $error("write did not end after one state");
   a_addr_hold: assert property (sel ##1 sel |-> $stable(ADDR_OUT))
      else $error("address moved inside a cycle");
   a_done_idle: assert property (DONE_OUT |-> READY_OUT && !sel)
      else $error("done while bus still selected");
endmodule
bind bus_seq bus_seq_assertions bus_seq_assertions_inst (.*);

//--- test/bus_partner.sv
// Purpose: memory or peripheral on the far side of the bus
// Assumes: read data is the address low byte xor A5
// Notes: slow mode pulls wait low one clock after a strobe falls
`timescale 1ns/10ps
module bus_partner (
   input wire logic clk_in,
   input wire logic slow_in,
   input wire logic [23:0] addr_in,
   input wire logic [3:0] cs_n_in,
   input wire logic rd_n_in,
   input wire logic wr_n_in,
   output logic [7:0] data_out,
   output logic waitn_out
);
   logic [7:0] last_r = 8'h00;
   logic [3:0] wait_cnt_r = 4'h0;
   logic idle_r = 1'h1;
   wire idle = rd_n_in & wr_n_in;
   // a released bus must not keep showing stale data
   assign data_out = !rd_n_in && cs_n_in != 4'hF ?
      addr_in[7:0] ^ 8'hA5 : ~last_r;
   assign waitn_out = wait_cnt_r == 4'h0;
   // wait low long before the third state ends
   always @(posedge clk_in) begin
      last_r <= data_out;
      idle_r <= idle;
      if (idle_r && !idle && slow_in)
         wait_cnt_r <= 4'h6;
      else if (wait_cnt_r != 4'h0)
         wait_cnt_r <= wait_cnt_r - 4'h1;
   end
endmodule

//--- test/separate_bus_cycle_sequencer_bench.sv
// Purpose: self-checking bench for bus_seq
// Assumes: partner answers reads from the address
// Notes: cycles counted from the take edge to done
`timescale 1ns/10ps
module separate_bus_cycle_sequencer_bench;
   logic CLK_IN = 0, RESETN_IN = 0, REQ_IN = 0, WRITE_IN = 0, IO_IN = 0;
   logic WAITN_IN, READY_OUT, DONE_OUT, DATA_OE_OUT, ALE_OUT;
   logic RD_N_OUT, WR_N_OUT, MEMORY_REQUEST_N_OUT, IO_REQUEST_N_OUT;
   logic [23:0] ADDR_IN = 0, ADDR_OUT;
   logic [7:0] WDATA_IN = 0, DATA_IN, RDATA_OUT, DATA_OUT;
   logic [3:0] CS_SEL_IN = 0, STATE_LEN_IN = 0, CS_N_OUT;
   logic slow = 0;
   int n_errors = 0, total_checks = 0;
   bus_seq bus_seq_inst (.*);
   bus_partner bus_partner_inst (.clk_in(CLK_IN), .slow_in(slow),
      .addr_in(ADDR_OUT), .cs_n_in(CS_N_OUT), .rd_n_in(RD_N_OUT),
      .wr_n_in(WR_N_OUT), .data_out(DATA_IN), .waitn_out(WAITN_IN));
   always #5 CLK_IN = ~CLK_IN;
   task automatic chk(input logic [63:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one bus cycle; l is the length after clamping
   task automatic cyc(input logic w, io, input logic [23:0] a,
         input logic [7:0] d, input logic [3:0] cs, ln, input int l);
      int n;
      n = 0;
      @(posedge CLK_IN);
      {REQ_IN, WRITE_IN, IO_IN} <= {1'h1, w, io};
      {ADDR_IN, WDATA_IN, CS_SEL_IN, STATE_LEN_IN} <= {a, d, cs, ln};
      @(posedge CLK_IN);
      REQ_IN <= 1'h0;
      do begin
         @(posedge CLK_IN);
         #1 n++;
         if (n == 1) chk({ALE_OUT, DATA_OE_OUT, CS_N_OUT, ADDR_OUT,
            w ? DATA_OUT : d}, {1'h1, w, ~cs, a, d});
         if (n == l + 1) chk({WR_N_OUT, RD_N_OUT,
            MEMORY_REQUEST_N_OUT, IO_REQUEST_N_OUT}, {~w, w, io, ~io});
      end while (!DONE_OUT && n < 200);
      if (slow)
         chk(n >= 5 * l && n <= 8 * l, 1);
      else
         chk(n, 4 * l);
      if (!w) chk(RDATA_OUT, a[7:0] ^ 8'hA5);
   endtask
   task t_write;
      cyc(1'h1, 1'h0, 24'h12345A, 8'hC3, 4'h1, 4'h2, 2);
      cyc(1'h1, 1'h1, 24'hFEDCB0, 8'h3C, 4'h8, 4'hF, 15);
   endtask
   task t_read;
      cyc(1'h0, 1'h1, 24'h000F0F, 8'h00, 4'h2, 4'h3, 3);
      cyc(1'h0, 1'h0, 24'hABCDEF, 8'h00, 4'h4, 4'h1, 2);
   endtask
   task t_wait;
      slow = 1'h1;
      cyc(1'h1, 1'h0, 24'h00A5A5, 8'h96, 4'h1, 4'h2, 2);
      cyc(1'h0, 1'h1, 24'h5A5A00, 8'h00, 4'h8, 4'h2, 2);
      slow = 1'h0;
   endtask
   task conclude;
      if (n_errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge CLK_IN);
      RESETN_IN <= 1'h1;
      t_write;
      t_read;
      t_wait;
      conclude;
   end
   // whole run needs well under two hundred cycles
   initial begin
      repeat (3000) @(posedge CLK_IN);
      n_errors++;
      conclude;
   end
endmodule
